// ===== rtl/lks_pkg.sv
// Constants and types for the link ordered-set and status block.
// Assumes a PHY with 16-bit data and a K flag per byte, low byte sent first.
package lks_pkg;
    // Control and data characters, 8-bit decoded values
    localparam logic [7:0] K_COMMA     = 8'hBC;  // K28.5
    localparam logic [7:0] K_SKIP      = 8'h1C;  // K28.0
    localparam logic [7:0] K_TRAIN     = 8'h3C;  // K28.1
    localparam logic [7:0] K_IDLE      = 8'h7C;  // K28.3
    localparam logic [7:0] K_VERSION   = 8'hF7;  // K23.7
    localparam logic [7:0] K_CELL_OPEN = 8'hFB;  // K27.7
    localparam logic [7:0] K_CELL_END  = 8'h5C;  // K28.2
    localparam logic [7:0] K_FRAME_END = 8'hFD;  // K29.7
    localparam logic [7:0] K_FRAME_ERR = 8'hFE;  // K30.7
    localparam logic [7:0] D_TRAIN     = 8'h4A;  // D10.2
    localparam logic [7:0] D_TRAIN_INV = 8'hB5;  // D21.5
    // Register offsets (byte addresses)
    localparam logic [3:0] ADR_CTRL    = 4'h0;
    localparam logic [3:0] ADR_STATUS  = 4'h4;
    localparam logic [3:0] ADR_VERSION = 4'h8;
    // Field positions
    localparam int CTRL_RELINK_BIT = 0;
    localparam int CTRL_HOLD_BIT   = 1;
    localparam int STAT_FAIL_BIT   = 4;
    localparam int STAT_UP_BIT     = 5;
    localparam int STAT_INV_BIT    = 6;
    localparam int STAT_SKIP_BIT   = 7;
    localparam int VER_PEER_LSB    = 8;
    // Event vector positions
    localparam int EVT_LOST  = 0;
    localparam int EVT_DISP  = 1;
    localparam int EVT_CODE  = 2;
    localparam int EVT_ACKQ  = 3;
    localparam int EVT_NACK  = 4;
    localparam int EVT_CSUM  = 5;
    localparam int EVT_SEQ   = 6;
    // Timing counts in core clocks and ordered sets
    localparam int RESET_CYCLES    = 16;
    localparam int IDLE_RX_NEED    = 8;
    localparam int TRAIN_RX_NEED   = 8;
    localparam int TRAIN_TIMEOUT   = 1024;
    localparam int INVERT_TX_SETS  = 16;
    localparam int VERSION_TX_SETS = 16;
    localparam int SKIP_PERIOD     = 2048;
    localparam int SKIP_SETS       = 2;

    typedef enum logic [3:0] {
        LKS_RESET   = 4'b0000,
        LKS_IDLE    = 4'b0001,
        LKS_TRAIN   = 4'b0011,
        LKS_INVERT  = 4'b0010,
        LKS_VERSION = 4'b0110,
        LKS_NORMAL  = 4'b0111,
        LKS_SKIP    = 4'b0101,
        LKS_FAIL    = 4'b0100
    } lks_state_t;
endpackage : lks_pkg

// ===== rtl/lks_link.sv
// Link ordered-set generator/recogniser with status and event outputs.
// Assumes all inputs synchronous to core_clk_i; a classic Wishbone master.
`timescale 1ns/10ps
// What this block does
// - Events are one-cycle pulses, no counters kept
// - Output own and peer version identifiers
// - Output link state as 4-bit code
// - Flag link failure when link cannot form
// - Link up only while link healthy
// - Pulse link-lost on relink request or loss
// - Pulse on receive running-disparity error
// - Pulse on invalid code group received
// - Pulse when acknowledge queue becomes full
// - Pulse when a NACK reaches user
// - Pulse on cell checksum mismatch
// - Pulse on sequence exhaustion, halt transmission
// - Ordered sets start with comma, used for alignment
// - Cells open with start-of-cell character
// - Cells close with one of three ends
// - Send idle after reset; idle received reinitialises
// - Training set: comma, train, D10.2, train
// - D21.5 means inverted pair, D10.2 normal
// - Periodic skip sets: comma plus three skips
// - Accept skip sets of any length
// - Version set: comma, version, id, version
// - Version mismatch fails link initialisation
// - Drive receive-invert control to PHY
// - Mismatch goes to failure state, not normal
// - Skip sets only between cells
module lks_link #(
    parameter logic [7:0] OWN_VERSION = 8'h5A,  // Arbitrary value
    parameter int TRAIN_TIMEOUT_CLKS = lks_pkg::TRAIN_TIMEOUT,
    parameter int SKIP_PERIOD_CLKS   = lks_pkg::SKIP_PERIOD
) (
    input  wire logic        core_clk_i,          // Core clock, 40 MHz
    input  wire logic        rst_n_i,             // Async reset, active low
    input  wire logic        ce_i,                // Clock enable, freezes all state
    input  wire logic        wb_cyc_i,            // Wishbone cycle
    input  wire logic        wb_stb_i,            // Wishbone strobe
    input  wire logic        wb_we_i,             // Wishbone write
    input  wire logic [3:0]  wb_adr_i,            // Wishbone byte address
    input  wire logic [3:0]  wb_sel_i,            // Wishbone byte enables
    input  wire logic [31:0] wb_dat_i,            // Wishbone write data
    output logic      [31:0] wb_dat_o,            // Wishbone read data
    output logic             wb_ack_o,            // Wishbone acknowledge
    input  wire logic [15:0] phy_rx_data_i,       // PHY receive word
    input  wire logic [1:0]  phy_rx_k_i,          // PHY receive K flags
    input  wire logic [1:0]  phy_disp_err_i,      // PHY disparity error per byte
    input  wire logic [1:0]  phy_code_err_i,      // PHY decode error per byte
    input  wire logic        phy_rx_lost_i,       // PHY lost the receive signal
    output logic      [15:0] phy_tx_data_o,       // PHY transmit word
    output logic      [1:0]  phy_tx_k_o,          // PHY transmit K flags
    output logic             rx_invert_ctl_o,     // Invert received data in PHY
    input  wire logic [15:0] cell_tx_data_i,      // Cell words to send in normal state
    input  wire logic [1:0]  cell_tx_k_i,         // Cell word K flags
    output logic             cell_tx_en_o,        // Cell words are being sent
    output logic             skip_req_o,          // Skip request to scheduler
    input  wire logic        skip_ack_i,          // Scheduler: current cell finished
    output logic      [15:0] cell_rx_data_o,      // Received word to cell receiver
    output logic      [1:0]  cell_rx_k_o,         // Received word K flags
    output logic             cell_rx_valid_o,     // Received word valid
    output logic             cell_open_o,         // Start-of-cell seen
    output logic             cell_end_o,          // Plain end-of-cell seen
    output logic             frame_end_o,         // End of last cell of frame
    output logic             frame_err_close_char_o, // End of errored frame
    input  wire logic        ack_queue_full_i,    // Acknowledge queue full level
    input  wire logic        neg_ack_i,           // NACK strobe to user logic
    input  wire logic        checksum_err_i,      // Cell checksum mismatch strobe
    input  wire logic        seq_exhausted_i,     // No free sequence numbers level
    output logic             tx_halt_o,           // Frame transmission halted
    output logic      [7:0]  own_version_id_o,    // Own version id
    output logic      [7:0]  peer_version_id_o,   // Peer version id
    output lks_pkg::lks_state_t link_fsm_state_o, // Link state code
    output logic             link_failed_o,       // Link could not be formed
    output logic             link_up_o,           // Link ready for data
    output logic             evt_link_lost_o,     // Link-lost pulse
    output logic             evt_disparity_err_o, // Disparity error pulse
    output logic             evt_code_err_o,      // Code error pulse
    output logic             evt_ack_queue_full_o,// Ack queue full pulse
    output logic             evt_neg_ack_o,       // NACK pulse
    output logic             evt_checksum_err_o,  // Checksum error pulse
    output logic             evt_seq_exhausted_o  // Sequence exhausted pulse
);
    import lks_pkg::*;

    if (TRAIN_TIMEOUT_CLKS < 2 || TRAIN_TIMEOUT_CLKS > 65535 ||
        SKIP_PERIOD_CLKS < 2 || SKIP_PERIOD_CLKS > 65535) begin : g_bad_params
        $error("lks_link: count parameters out of range");
    end

    typedef struct packed {
        lks_state_t  state;
        logic        phase;
        logic [15:0] cnt;
        logic [7:0]  sets;
        logic        got_ver;
        logic        rx_hdr;
        logic [7:0]  rx_ctl;
        logic        invert;
        logic [7:0]  own_ver;
        logic [7:0]  peer_ver;
        logic [15:0] tx_data;
        logic [1:0]  tx_k;
        logic        skip_req;
        logic        hold;
        logic [17:0] rx_word;
        logic        rx_valid;
        logic [3:0]  delim;
        logic [6:0]  evt;
        logic        ackq_d;
        logic        seq_d;
        logic        halt;
        logic        tx_en;
        logic        failed;
        logic        wb_ack;
        logic [31:0] wb_dat;
    } lks_regs_t;

    localparam logic [7:0] DELIM_CODE [4] = '{K_CELL_OPEN, K_CELL_END, K_FRAME_END,
                                              K_FRAME_ERR};

    lks_regs_t r_ff;
    lks_regs_t nxt_r;
    logic      set_idle;
    logic      set_train;
    logic      set_ver;
    logic      wr_relink;

    // One word of an ordered set, {k flags, data}
    function automatic logic [17:0] os_word(input logic [7:0] ctl, input logic ph,
                                            input logic [7:0] dbyte, input logic dk);
        if (!ph) begin
            os_word = {2'b11, ctl, K_COMMA};
        end else begin
            os_word = {1'b1, dk, ctl, dbyte};
        end
    endfunction : os_word

    assign wr_relink = wb_cyc_i && wb_stb_i && r_ff.wb_ack && wb_we_i &&
                       wb_adr_i == ADR_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_RELINK_BIT];

    always_comb begin
        logic [17:0] tx;
        logic        set_done;
        logic        relink;
        nxt_r    = r_ff;
        tx       = '0;
        relink   = 1'b0;
        set_done = r_ff.phase;
        // Comma word opens a set; its control byte is kept to match the next word
        nxt_r.rx_hdr = phy_rx_k_i == 2'b11 && phy_rx_data_i[7:0] == K_COMMA;
        nxt_r.rx_ctl = phy_rx_data_i[15:8];
        // Skip sets of any length fall through: no second word is matched
        set_idle  = r_ff.rx_hdr && r_ff.rx_ctl == K_IDLE && phy_rx_k_i[1] &&
                    phy_rx_data_i[15:8] == K_IDLE;
        set_train = r_ff.rx_hdr && r_ff.rx_ctl == K_TRAIN && phy_rx_k_i == 2'b10 &&
                    phy_rx_data_i[15:8] == K_TRAIN;
        set_ver   = r_ff.rx_hdr && r_ff.rx_ctl == K_VERSION && phy_rx_k_i == 2'b10 &&
                    phy_rx_data_i[15:8] == K_VERSION;

        // Wishbone: ack one cycle after request, write applied at the acked edge
        nxt_r.wb_ack = wb_cyc_i && wb_stb_i && !r_ff.wb_ack;
        nxt_r.wb_dat = '0;
        if (wb_cyc_i && wb_stb_i && !r_ff.wb_ack && !wb_we_i) begin
            if (wb_adr_i == ADR_CTRL) begin
                nxt_r.wb_dat[CTRL_HOLD_BIT] = r_ff.hold;
            end else if (wb_adr_i == ADR_STATUS) begin
                nxt_r.wb_dat[3:0]           = r_ff.state;
                nxt_r.wb_dat[STAT_FAIL_BIT] = r_ff.state == LKS_FAIL;
                nxt_r.wb_dat[STAT_UP_BIT]   = r_ff.state == LKS_NORMAL ||
                                              r_ff.state == LKS_SKIP;
                nxt_r.wb_dat[STAT_INV_BIT]  = r_ff.invert;
                nxt_r.wb_dat[STAT_SKIP_BIT] = r_ff.skip_req;
            end else if (wb_adr_i == ADR_VERSION) begin
                nxt_r.wb_dat[7:0]                       = r_ff.own_ver;
                nxt_r.wb_dat[VER_PEER_LSB +: 8]         = r_ff.peer_ver;
            end
        end
        if (wb_cyc_i && wb_stb_i && r_ff.wb_ack && wb_we_i && wb_adr_i == ADR_CTRL &&
            wb_sel_i[0]) begin
            nxt_r.hold = wb_dat_i[CTRL_HOLD_BIT];
        end
        relink = wr_relink || r_ff.hold;

        nxt_r.phase = !r_ff.phase;
        nxt_r.cnt   = r_ff.cnt + 16'h0001;
        nxt_r.evt   = '0;
        case (r_ff.state)
            LKS_RESET: begin
                if (r_ff.cnt == 16'(RESET_CYCLES - 1) && set_done) begin
                    nxt_r.state = LKS_IDLE;
                    nxt_r.cnt   = '0;
                    nxt_r.sets  = '0;
                end
            end
            LKS_IDLE: begin
                if (set_idle) begin
                    nxt_r.sets = r_ff.sets + 8'h01;
                end
                if (r_ff.sets >= 8'(IDLE_RX_NEED) && set_done) begin
                    nxt_r.state = LKS_TRAIN;
                    nxt_r.cnt   = '0;
                    nxt_r.sets  = '0;
                end
            end
            LKS_TRAIN: begin
                if (set_train) begin
                    nxt_r.sets = r_ff.sets + 8'h01;
                    nxt_r.cnt  = '0;
                end
                if (r_ff.sets >= 8'(TRAIN_RX_NEED) && set_done) begin
                    nxt_r.state = LKS_INVERT;
                    nxt_r.sets  = '0;
                end else if (r_ff.cnt == 16'(TRAIN_TIMEOUT_CLKS - 1)) begin
                    nxt_r.state = LKS_IDLE;
                    nxt_r.cnt   = '0;
                    nxt_r.sets  = '0;
                end
            end
            LKS_INVERT: begin
                if (set_train && phy_rx_data_i[7:0] == D_TRAIN_INV) begin
                    nxt_r.invert = !r_ff.invert;
                end
                if (set_done) begin
                    nxt_r.sets = r_ff.sets + 8'h01;
                end
                if (set_done && r_ff.sets == 8'(INVERT_TX_SETS - 1)) begin
                    nxt_r.state   = LKS_VERSION;
                    nxt_r.sets    = '0;
                    nxt_r.got_ver = 1'b0;
                end
            end
            LKS_VERSION: begin
                if (set_done && r_ff.sets != 8'(VERSION_TX_SETS)) begin
                    nxt_r.sets = r_ff.sets + 8'h01;
                end
                if (set_ver) begin
                    nxt_r.peer_ver = phy_rx_data_i[7:0];
                    nxt_r.got_ver  = 1'b1;
                end
                if (set_ver && phy_rx_data_i[7:0] != r_ff.own_ver) begin
                    nxt_r.state = LKS_FAIL;
                end else if (r_ff.got_ver && r_ff.sets == 8'(VERSION_TX_SETS) &&
                             set_done) begin
                    nxt_r.state = LKS_NORMAL;
                    nxt_r.cnt   = '0;
                end
            end
            LKS_NORMAL: begin
                if (r_ff.cnt == 16'(SKIP_PERIOD_CLKS - 1)) begin
                    nxt_r.skip_req = 1'b1;
                end
                if (r_ff.skip_req && skip_ack_i) begin
                    nxt_r.state = LKS_SKIP;
                    nxt_r.phase = 1'b0;
                    nxt_r.sets  = '0;
                end
            end
            LKS_SKIP: begin
                if (set_done) begin
                    nxt_r.sets = r_ff.sets + 8'h01;
                end
                if (set_done && r_ff.sets == 8'(SKIP_SETS - 1)) begin
                    nxt_r.state    = LKS_NORMAL;
                    nxt_r.skip_req = 1'b0;
                    nxt_r.cnt      = '0;
                end
            end
            LKS_FAIL: begin
                nxt_r.cnt = '0;
            end
            default: begin
                nxt_r.state = LKS_RESET;
            end
        endcase
        // Relink, or peer idle or signal loss in normal/skip, restarts the link
        if (relink || ((r_ff.state == LKS_NORMAL || r_ff.state == LKS_SKIP) &&
                       (set_idle || phy_rx_lost_i))) begin
            nxt_r.state = LKS_RESET;
            nxt_r.cnt   = '0;
            nxt_r.phase = 1'b0;
            nxt_r.evt[EVT_LOST] = r_ff.state != LKS_RESET;
        end
        if (nxt_r.state == LKS_RESET) begin
            nxt_r.peer_ver = '0;
            nxt_r.skip_req = 1'b0;
            nxt_r.got_ver  = 1'b0;
        end

        case (nxt_r.state)
            LKS_TRAIN, LKS_INVERT: tx = os_word(K_TRAIN, nxt_r.phase, D_TRAIN, 1'b0);
            LKS_VERSION: tx = os_word(K_VERSION, nxt_r.phase, r_ff.own_ver, 1'b0);
            LKS_SKIP:    tx = os_word(K_SKIP, nxt_r.phase, K_SKIP, 1'b1);
            LKS_NORMAL:  tx = {cell_tx_k_i, cell_tx_data_i};
            default:     tx = os_word(K_IDLE, nxt_r.phase, K_IDLE, 1'b1);
        endcase
        nxt_r.tx_k    = tx[17:16];
        nxt_r.tx_data = tx[15:0];

        // Received words and cell delimiters for the cell receiver
        nxt_r.rx_word  = {phy_rx_k_i, phy_rx_data_i};
        // Status outputs registered from the next state so they track it exactly
        nxt_r.tx_en    = nxt_r.state == LKS_NORMAL;
        nxt_r.failed   = nxt_r.state == LKS_FAIL;
        nxt_r.rx_valid = nxt_r.state == LKS_NORMAL || nxt_r.state == LKS_SKIP;
        for (int i = 0; i < 4; i++) begin
            nxt_r.delim[i] = nxt_r.rx_valid &&
                ((phy_rx_k_i[0] && phy_rx_data_i[7:0] == DELIM_CODE[i]) ||
                 (phy_rx_k_i[1] && phy_rx_data_i[15:8] == DELIM_CODE[i]));
        end

        // Events: one-cycle pulses, no counting kept here
        nxt_r.ackq_d        = ack_queue_full_i;
        nxt_r.seq_d         = seq_exhausted_i;
        nxt_r.halt          = seq_exhausted_i;
        nxt_r.evt[EVT_DISP] = |phy_disp_err_i;
        nxt_r.evt[EVT_CODE] = |phy_code_err_i;
        nxt_r.evt[EVT_ACKQ] = ack_queue_full_i && !r_ff.ackq_d;
        nxt_r.evt[EVT_NACK] = neg_ack_i;
        nxt_r.evt[EVT_CSUM] = checksum_err_i;
        nxt_r.evt[EVT_SEQ]  = seq_exhausted_i && !r_ff.seq_d;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r_ff         <= '0;
            r_ff.own_ver <= OWN_VERSION;
        end else if (ce_i) begin
            r_ff <= nxt_r;
        end
    end

    assign wb_dat_o               = r_ff.wb_dat;
    assign wb_ack_o               = r_ff.wb_ack;
    assign phy_tx_data_o          = r_ff.tx_data;
    assign phy_tx_k_o             = r_ff.tx_k;
    assign rx_invert_ctl_o        = r_ff.invert;
    assign cell_tx_en_o           = r_ff.tx_en;
    assign skip_req_o             = r_ff.skip_req;
    assign cell_rx_data_o         = r_ff.rx_word[15:0];
    assign cell_rx_k_o            = r_ff.rx_word[17:16];
    assign cell_rx_valid_o        = r_ff.rx_valid;
    assign cell_open_o            = r_ff.delim[0];
    assign cell_end_o             = r_ff.delim[1];
    assign frame_end_o            = r_ff.delim[2];
    assign frame_err_close_char_o = r_ff.delim[3];
    assign tx_halt_o              = r_ff.halt;
    assign own_version_id_o       = r_ff.own_ver;
    assign peer_version_id_o      = r_ff.peer_ver;
    assign link_fsm_state_o       = r_ff.state;
    assign link_failed_o          = r_ff.failed;
    assign link_up_o              = r_ff.rx_valid;
    assign evt_link_lost_o        = r_ff.evt[EVT_LOST];
    assign evt_disparity_err_o    = r_ff.evt[EVT_DISP];
    assign evt_code_err_o         = r_ff.evt[EVT_CODE];
    assign evt_ack_queue_full_o   = r_ff.evt[EVT_ACKQ];
    assign evt_neg_ack_o          = r_ff.evt[EVT_NACK];
    assign evt_checksum_err_o     = r_ff.evt[EVT_CSUM];
    assign evt_seq_exhausted_o    = r_ff.evt[EVT_SEQ];

    default clocking cb @(posedge core_clk_i iff ce_i); endclocking
    default disable iff (!rst_n_i);

    property p_lost_pulse;
        evt_link_lost_o |=> !evt_link_lost_o;
    endproperty
    a_lost_pulse: assert property (p_lost_pulse) else $error("link-lost wider than one");
    property p_up_state;
        link_up_o |-> !link_failed_o && link_fsm_state_o inside {LKS_NORMAL, LKS_SKIP};
    endproperty
    a_up_state: assert property (p_up_state) else $error("link up in wrong state");
    property p_fail_state;
        (link_fsm_state_o == LKS_FAIL) == link_failed_o;
    endproperty
    a_fail_state: assert property (p_fail_state) else $error("fail flag mismatch");
    property p_relink;
        wr_relink && link_fsm_state_o != LKS_RESET |=>
            evt_link_lost_o && link_fsm_state_o == LKS_RESET;
    endproperty
    a_relink: assert property (p_relink) else $error("relink missed");
    property p_disp;
        |phy_disp_err_i |=> evt_disparity_err_o;
    endproperty
    a_disp: assert property (p_disp) else $error("disparity event missed");
    property p_code;
        |phy_code_err_i |=> evt_code_err_o;
    endproperty
    a_code: assert property (p_code) else $error("code event missed");
    property p_ackq;
        $rose(ack_queue_full_i) |=> evt_ack_queue_full_o ##1 !evt_ack_queue_full_o;
    endproperty
    a_ackq: assert property (p_ackq) else $error("ack queue event wrong");
    property p_halt;
        seq_exhausted_i |=> tx_halt_o;
    endproperty
    a_halt: assert property (p_halt) else $error("transmission not halted");
    property p_train_word;
        link_fsm_state_o == LKS_TRAIN && phy_tx_k_o == 2'b10 |->
            phy_tx_data_o == {K_TRAIN, D_TRAIN};
    endproperty
    a_train_word: assert property (p_train_word) else $error("bad training word");
    property p_mismatch;
        link_fsm_state_o == LKS_VERSION && set_ver && !wr_relink && !r_ff.hold &&
            phy_rx_data_i[7:0] != own_version_id_o |=> link_fsm_state_o == LKS_FAIL;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not failed");
    property p_skip_entry;
        link_fsm_state_o == LKS_NORMAL ##1 link_fsm_state_o == LKS_SKIP |->
            $past(skip_ack_i);
    endproperty
    a_skip_entry: assert property (p_skip_entry) else $error("skip inside cell");
    property p_reset_clear;
        link_fsm_state_o == LKS_RESET |-> peer_version_id_o == 8'h00 && !link_up_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("status not cleared");

    c_normal: cover property (link_fsm_state_o == LKS_VERSION ##1 link_fsm_state_o == LKS_NORMAL);
    c_invert: cover property ($rose(rx_invert_ctl_o));
    c_fail:   cover property ($rose(link_failed_o));
    c_skip:   cover property (link_fsm_state_o == LKS_SKIP);
endmodule : lks_link

// ===== bench/lks_peer.sv
// Remote peer model: sends two-word ordered sets of the chosen kind.
// Assumes a PHY that complements data bytes while the pair is crossed.
`timescale 1ns/10ps
module lks_peer (
    input  wire logic        clk_i,  // Core clock
    input  wire logic [1:0]  mode_i, // 0 idle, 1 train, 2 version, 3 skip
    input  wire logic [7:0]  ver_i,  // Version byte sent
    input  wire logic        flip_i, // Pair crossed on the wire
    input  wire logic        inv_i,  // PHY receive inversion control
    output logic      [15:0] data_o, // Word seen by the receiver
    output logic      [1:0]  k_o     // K flags seen by the receiver
);
    import lks_pkg::*;
    localparam logic [3:0][7:0] CTL = {K_SKIP, K_VERSION, K_TRAIN, K_IDLE};
    logic       ph_ff = 1'b0;
    logic       dt;
    logic [7:0] c;
    logic [7:0] d;
    assign c  = CTL[mode_i];
    assign dt = ^mode_i;
    // Crossed pair turns D10.2 into D21.5 unless the PHY inverts back
    assign d  = (mode_i[0] ? D_TRAIN : ver_i) ^ {8{flip_i ^ inv_i}};
    initial data_o = 16'h0000;
    initial k_o = 2'b00;
    always @(posedge clk_i) begin
        ph_ff  <= !ph_ff;
        data_o <= {c, !ph_ff ? K_COMMA : dt ? d : c};
        k_o    <= {1'b1, !ph_ff || !dt};
    end
endmodule : lks_peer

// ===== bench/lks_link_tb.sv
// Self-checking bench: peer model on the PHY side, Wishbone master tasks.
// Assumes the design ports named as declared here, connected implicitly.
`timescale 1ns/10ps
module lks_link_tb;
    import lks_pkg::*;
    logic core_clk_i = 0, rst_n_i = 0, ce_i = 1, phy_rx_lost_i = 0, skip_ack_i = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [3:0] wb_adr_i = 0, wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic [15:0] phy_rx_data_i, phy_tx_data_o, cell_tx_data_i = 0, cell_rx_data_o;
    logic [1:0] phy_rx_k_i, phy_tx_k_o, cell_tx_k_i = 0, cell_rx_k_o, phy_disp_err_i, phy_code_err_i;
    logic ack_queue_full_i, neg_ack_i, checksum_err_i, seq_exhausted_i, rx_invert_ctl_o;
    logic cell_tx_en_o, skip_req_o, cell_rx_valid_o, cell_open_o, cell_end_o, frame_end_o;
    logic frame_err_close_char_o, tx_halt_o, link_failed_o, link_up_o, evt_link_lost_o;
    logic evt_disparity_err_o, evt_code_err_o, evt_ack_queue_full_o, evt_neg_ack_o;
    logic evt_checksum_err_o, evt_seq_exhausted_o, flip = 0;
    logic [7:0] own_version_id_o, peer_version_id_o, ver = 0;
    logic [1:0] mode = 0;
    logic [5:0] ev = 0, evo;
    lks_state_t link_fsm_state_o;
    int n_mismatch = 0, checks = 0;
    assign {seq_exhausted_i, checksum_err_i, neg_ack_i, ack_queue_full_i} = ev[5:2];
    assign phy_code_err_i = {1'b0, ev[1]};
    assign phy_disp_err_i = {1'b0, ev[0]};
    assign evo = {evt_seq_exhausted_o, evt_checksum_err_o, evt_neg_ack_o, evt_ack_queue_full_o,
                  evt_code_err_o, evt_disparity_err_o};
    lks_link #(.TRAIN_TIMEOUT_CLKS(32), .SKIP_PERIOD_CLKS(64)) i_dut (.*);
    lks_peer i_peer (.clk_i(core_clk_i), .mode_i(mode), .ver_i(ver), .flip_i(flip),
                     .inv_i(rx_invert_ctl_o), .data_o(phy_rx_data_i), .k_o(phy_rx_k_i));
    always #12.5 core_clk_i = !core_clk_i;
    task finish_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(posedge core_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 20) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wb
    task wait_st(input lks_state_t s);
        int n;
        n = 0;
        while (link_fsm_state_o !== s && n < 3000) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n >= 3000) begin
            n_mismatch++;
            finish_test();
        end
    endtask : wait_st
    task bring(input logic [7:0] v, input logic f, input lks_state_t s);
        @(posedge core_clk_i);
        {mode, ver, flip} <= {2'd0, v, f};
        wait_st(LKS_TRAIN);
        mode <= 2'd1;
        wait_st(LKS_VERSION);
        mode <= 2'd2;
        wait_st(s);
        mode <= 2'd3;
    endtask : bring
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1 chk({phy_tx_k_o, phy_tx_data_o[15:8], evo, peer_version_id_o, own_version_id_o},
               {2'b11, K_IDLE, 6'h00, 8'h00, 8'h5A});
        bring(8'h5A, 1'b1, LKS_NORMAL);
        #1 chk({link_up_o, rx_invert_ctl_o, link_failed_o, peer_version_id_o}, 11'h65A);
        wb(1'b0, ADR_STATUS, 0);
        chk(q, 32'h0000_0067);
        wb(1'b0, ADR_VERSION, 0);
        chk(q, 32'h0000_5A5A);
        wb(1'b0, 4'hC, 0);
        chk(q, 32'h0000_0000);
        cell_tx_data_i <= {K_FRAME_END, K_CELL_OPEN};
        cell_tx_k_i    <= 2'b11;
        @(posedge core_clk_i);
        #1 chk({cell_tx_en_o, phy_tx_k_o, phy_tx_data_o},
               {3'b111, K_FRAME_END, K_CELL_OPEN});
        repeat (80) @(posedge core_clk_i);
        #1 chk({skip_req_o, link_fsm_state_o}, {1'b1, LKS_NORMAL});
        @(posedge core_clk_i);
        skip_ack_i <= 1'b1;
        wait_st(LKS_SKIP);
        @(posedge core_clk_i);
        #1 chk({phy_tx_k_o, phy_tx_data_o[15:8], link_up_o}, {2'b11, K_SKIP, 1'b1});
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk_i);
            ev <= 6'b1 << i;
            @(posedge core_clk_i);
            ev <= 6'h00;
            #1 chk({tx_halt_o, evo}, {i == 5, 6'b1 << i});
            @(posedge core_clk_i);
            #1 chk(evo, 6'h00);
        end
        @(posedge core_clk_i);
        mode <= 2'd0;
        wait_st(LKS_RESET);
        #1 chk({link_up_o, peer_version_id_o}, 9'h000);
        wait_st(LKS_IDLE);
        wb(1'b1, ADR_CTRL, 1);
        #1 chk({evt_link_lost_o, link_fsm_state_o, peer_version_id_o}, {1'b1, LKS_RESET, 8'h00});
        bring(8'h33, 1'b0, LKS_FAIL);
        #1 chk({link_failed_o, link_up_o}, 2'b10);
        finish_test();
    end
endmodule : lks_link_tb
